// ==== rtl/rfcs_pkg.sv ====
// rfcs_pkg: register indices, field positions, reset values and timing of the front-end control bank
// assumes: one 20 MHz clock; register byte address is four times the index
package rfcs_pkg;

	localparam int NCH   = 4;
	localparam int NWB   = 3;
	localparam int MEAS_W = 6;
	localparam int TEMP_W = 10;

	////////////////////////////////////////////////////////////////////////
	// register indices (byte address = index * 4)
	localparam logic [7:0] IDX_TEMP_HI   = 8'h04;
	localparam logic [7:0] IDX_TEMP_LO   = 8'h05;
	localparam logic [7:0] IDX_TEMP_CTL  = 8'h09;
	localparam logic [7:0] IDX_CLK_SRC   = 8'h0A;
	localparam logic [7:0] IDX_CLK_DIV   = 8'h0B;
	localparam logic [7:0] IDX_CLK_OUT   = 8'h0C;
	localparam logic [7:0] IDX_ANT_STAT  = 8'h0E;
	localparam logic [7:0] IDX_ADC_CFG   = 8'h1C;
	localparam logic [7:0] IDX_ANT_CUR   = 8'h21;
	localparam logic [7:0] IDX_ANT_CTL   = 8'h22;
	localparam logic [7:0] IDX_ADC_CFG_D = 8'h5D;
	localparam logic [7:0] CH_STRIDE     = 8'h16;

	////////////////////////////////////////////////////////////////////////
	// field positions
	localparam int ADC_ANA_B   = 0;
	localparam int ADC_LVL_B   = 2;
	localparam int ADC_MODE_B  = 4;
	localparam int ADCD_ANA_B  = 2;
	localparam int ADCD_LVL_B  = 3;
	localparam int ADCD_MODE_B = 5;
	localparam int ANT_LIM_B   = 0;
	localparam int ANT_SET_B   = 4;
	localparam int CTL_TYPE_B  = 0;
	localparam int CTL_AMPEN_B = 1;
	localparam int CTL_DET_B   = 2;
	localparam int CTL_AUTO_B  = 3;
	localparam int ST_CUR_B    = 1;
	localparam int ST_CONN_B   = 2;
	localparam int ST_AMP_B    = 6;
	localparam int CLK_SRC_B   = 0;
	localparam int CLK_TYPE_B  = 3;
	localparam int CLK_CMOS_B  = 0;
	localparam int CLK_DC_B    = 3;
	localparam int CLK_AMP_B   = 5;
	localparam int TMP_START_B = 0;
	localparam int TMP_MODE_B  = 1;

	////////////////////////////////////////////////////////////////////////
	// codes
	localparam logic [1:0] ADC_ASYNC = 2'h0;
	localparam logic [1:0] ADC_FALL  = 2'h1;
	localparam logic [1:0] ADC_RISE  = 2'h2;
	localparam logic [1:0] CLKO_CMOS = 2'h0;
	localparam logic [1:0] CLKO_ECL  = 2'h1;
	localparam logic [1:0] CLKO_LVDS = 2'h2;
	localparam logic [2:0] SRC_SYNTH_FIRST = 3'h0;
	localparam logic [3:0] MIN_PRESET = 4'h0;

	////////////////////////////////////////////////////////////////////////
	// reset values
	localparam logic [1:0] RST_ADC_MODE = 2'h1;
	localparam logic [1:0] RST_ADC_LVL  = 2'h3;
	localparam logic [3:0] RST_CUR_SET  = 4'h0;
	localparam logic [7:0] RST_CLK_DIV  = 8'h16;
	localparam logic [1:0] RST_CLK_AMP  = 2'h1;
	localparam logic [1:0] RST_CLK_DC   = 2'h0;
	localparam logic [2:0] RST_CLK_CMOS = 3'h0;

	////////////////////////////////////////////////////////////////////////
	// timing
	localparam longint CLK_HZ         = 20000000;
	localparam longint TEMP_MEAS_MS   = 17;
	localparam longint TEMP_PERIOD_MS = 20;
	localparam int TEMP_MEAS_CYC   = int'(TEMP_MEAS_MS * CLK_HZ / 1000);
	localparam int TEMP_PERIOD_CYC = int'(TEMP_PERIOD_MS * CLK_HZ / 1000);

endpackage : rfcs_pkg

// ==== rtl/rfcs_antenna.sv ====
// rfcs_antenna: active antenna detector status and amplifier choice for one wideband channel
// assumes: measured current arrives in the same code scale as the current setting
`timescale 1ns/10ps
module rfcs_antenna (
	input  wire logic                          clk,
	input  wire logic                          reset_n,
	input  wire logic [3:0]                    cur_set,
	input  wire logic                          lim_min,
	input  wire logic                          det_en,
	input  wire logic                          auto_en,
	input  wire logic                          amp_en,
	input  wire logic                          amp_type,
	input  wire logic [rfcs_pkg::MEAS_W-1:0]   meas_cur,
	output logic                               conn_fail,
	output logic                               cur_fail,
	output logic [3:0]                         limit_preset,
	output logic                               limit_active,
	output logic [1:0]                         amp_status
);

	typedef struct packed {
		logic       conn_fail;
		logic       cur_fail;
		logic [3:0] limit_preset;
		logic       limit_active;
		logic [1:0] amp_status;
	} rfcs_ant_state_type;

	rfcs_ant_state_type state_reg;
	rfcs_ant_state_type state_next;
	logic               low_now;
	logic               high_now;

	always_comb begin
		low_now  = det_en & ({meas_cur, 2'b00} <= {4'h0, cur_set});
		high_now = det_en & ({1'b0, meas_cur} >= {2'b00, cur_set, 1'b0});
		state_next = state_reg;
		// flags follow the detector every cycle, nothing to acknowledge
		state_next.conn_fail    = low_now;
		state_next.cur_fail     = high_now;
		state_next.limit_preset = lim_min ? rfcs_pkg::MIN_PRESET : cur_set;
		state_next.limit_active = high_now;
		if (auto_en && det_en) begin
			// a connected active antenna gets the first amplifier
			state_next.amp_status = low_now ? 2'b10 : 2'b01;
		end else begin
			state_next.amp_status = {amp_en & amp_type, amp_en & ~amp_type};
		end
	end

	always_ff @(posedge clk) begin
		if (!reset_n) begin
			state_reg <= '0;
		end else begin
			state_reg <= state_next;
		end
	end

	assign conn_fail    = state_reg.conn_fail;
	assign cur_fail     = state_reg.cur_fail;
	assign limit_preset = state_reg.limit_preset;
	assign limit_active = state_reg.limit_active;
	assign amp_status   = state_reg.amp_status;

endmodule : rfcs_antenna

// ==== rtl/rfcs_temp.sv ====
// rfcs_temp: single or continuous temperature measurement sequencer
// assumes: sensor value is stable by the end of the measurement time
`timescale 1ns/10ps
module rfcs_temp #(
	parameter int MEAS_CYC   = rfcs_pkg::TEMP_MEAS_CYC,
	parameter int PERIOD_CYC = rfcs_pkg::TEMP_PERIOD_CYC
) (
	input  wire logic                        clk,
	input  wire logic                        reset_n,
	input  wire logic                        start,
	input  wire logic                        cont_mode,
	input  wire logic [rfcs_pkg::TEMP_W-1:0] sensor_value,
	output logic                             finish,
	output logic                             sense_en,
	output logic [rfcs_pkg::TEMP_W-1:0]      result
);

	typedef enum logic [1:0] {
		TS_IDLE,
		TS_MEAS,
		TS_WAIT
	} rfcs_tstate_type;

	typedef struct packed {
		rfcs_tstate_type             st;
		logic [31:0]                 cnt;
		logic                        finish;
		logic [rfcs_pkg::TEMP_W-1:0] result;
	} rfcs_temp_state_type;

	rfcs_temp_state_type state_reg;
	rfcs_temp_state_type state_next;

	always_comb begin
		state_next        = state_reg;
		state_next.finish = 1'b0;
		state_next.cnt    = state_reg.cnt + 32'h1;
		case (state_reg.st)
			TS_IDLE: begin
				state_next.cnt = '0;
				if (start && !state_reg.finish) begin
					state_next.st = TS_MEAS;
				end
			end
			TS_MEAS: begin
				if (state_reg.cnt == 32'(MEAS_CYC - 1)) begin
					state_next.result = sensor_value;
					state_next.cnt    = '0;
					if (cont_mode) begin
						state_next.st = TS_WAIT;
					end else begin
						state_next.st     = TS_IDLE;
						state_next.finish = 1'b1;
					end
				end
			end
			TS_WAIT: begin
				if (!cont_mode) begin
					state_next.st     = TS_IDLE;
					state_next.finish = 1'b1;
				end else if (state_reg.cnt == 32'(PERIOD_CYC - MEAS_CYC - 1)) begin
					state_next.st  = TS_MEAS;
					state_next.cnt = '0;
				end
			end
			default: begin
				state_next.st = TS_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk) begin
		if (!reset_n) begin
			state_reg <= '{st: TS_IDLE, default: '0};
		end else begin
			state_reg <= state_next;
		end
	end

	assign finish   = state_reg.finish;
	assign sense_en = (state_reg.st == TS_MEAS);
	assign result   = state_reg.result;

endmodule : rfcs_temp

// ==== rtl/rfcs_top.sv ====
// rfcs_top: configuration and status bank of a multi-channel receiver front end, APB slave
// assumes: apb master obeys setup/access phases; detector and sensor inputs synchronous to clk
`timescale 1ns/10ps
module rfcs_top #(
	parameter int TEMP_MEAS_CYCLES   = rfcs_pkg::TEMP_MEAS_CYC,
	parameter int TEMP_PERIOD_CYCLES = rfcs_pkg::TEMP_PERIOD_CYC
) (
	input  wire logic                                   clk,
	input  wire logic                                   reset_n,
	input  wire logic                                   psel,
	input  wire logic                                   penable,
	input  wire logic                                   pwrite,
	input  wire logic [9:0]                             paddr,
	input  wire logic [31:0]                            pwdata,
	output logic [31:0]                                 prdata,
	output logic                                        pready,
	output logic                                        pslverr,
	input  wire logic [rfcs_pkg::NWB-1:0][rfcs_pkg::MEAS_W-1:0] ant_meas_cur,
	input  wire logic [rfcs_pkg::TEMP_W-1:0]            temp_sensor_value,
	output logic [rfcs_pkg::NCH-1:0]                    adc_analog_sel,
	output logic [rfcs_pkg::NCH-1:0][1:0]               adc_clk_mode,
	output logic [rfcs_pkg::NCH-1:0]                    adc_sample_clk_en,
	output logic [rfcs_pkg::NCH-1:0][1:0]               adc_high_level,
	output logic [rfcs_pkg::NWB-1:0]                    ant_conn_fail,
	output logic [rfcs_pkg::NWB-1:0]                    ant_cur_fail,
	output logic [rfcs_pkg::NWB-1:0][3:0]               ant_limit_preset,
	output logic [rfcs_pkg::NWB-1:0]                    ant_limit_active,
	output logic [rfcs_pkg::NWB-1:0]                    first_input_amplifier_on,
	output logic [rfcs_pkg::NWB-1:0]                    second_input_amplifier_on,
	output logic [2:0]                                  clk_src_sel,
	output logic [7:0]                                  clk_div,
	output logic [1:0]                                  clk_out_type,
	output logic [1:0]                                  clk_amp,
	output logic [1:0]                                  clk_ecl_dc,
	output logic [2:0]                                  clk_cmos_level,
	output logic                                        temp_sense_en
);

	localparam int NCH = rfcs_pkg::NCH;
	localparam int NWB = rfcs_pkg::NWB;

	typedef struct packed {
		logic [NCH-1:0]      analog;
		logic [NCH-1:0][1:0] adc_mode;
		logic [NCH-1:0][1:0] adc_lvl;
		logic [NWB-1:0][3:0] cur_set;
		logic [NWB-1:0]      lim_min;
		logic [NWB-1:0]      auto_en;
		logic [NWB-1:0]      det_en;
		logic [NWB-1:0]      amp_en;
		logic [NWB-1:0]      amp_type;
		logic [2:0]          clk_src;
		logic [7:0]          clk_div;
		logic [1:0]          clk_type;
		logic [1:0]          clk_amp;
		logic [1:0]          clk_dc;
		logic [2:0]          clk_cmos;
		logic                temp_mode;
		logic                temp_start;
		logic [31:0]         rdata;
		logic                err;
	} rfcs_top_state_type;

	rfcs_top_state_type              state_reg;
	rfcs_top_state_type              state_next;
	logic [7:0]                      idx;
	logic                            setup;
	logic                            wr;
	logic                            hit;
	logic [31:0]                     rval;
	logic                            temp_finish;
	logic [rfcs_pkg::TEMP_W-1:0]     temp_result;
	logic [NWB-1:0][1:0]             amp_status;

	////////////////////////////////////////////////////////////////////////
	// read decode; address taken in the setup phase
	assign idx   = paddr[9:2];
	assign setup = psel & ~penable;
	assign wr    = psel & penable & pwrite;

	always_comb begin
		hit  = 1'b0;
		rval = '0;
		case (idx)
			rfcs_pkg::IDX_TEMP_HI: begin
				hit  = 1'b1;
				rval = {30'h0, temp_result[9:8]};
			end
			rfcs_pkg::IDX_TEMP_LO: begin
				hit  = 1'b1;
				rval = {24'h0, temp_result[7:0]};
			end
			rfcs_pkg::IDX_TEMP_CTL: begin
				hit = 1'b1;
				rval[rfcs_pkg::TMP_MODE_B]  = state_reg.temp_mode;
				rval[rfcs_pkg::TMP_START_B] = state_reg.temp_start;
			end
			rfcs_pkg::IDX_CLK_SRC: begin
				hit = 1'b1;
				rval[rfcs_pkg::CLK_SRC_B+:3]  = state_reg.clk_src;
				rval[rfcs_pkg::CLK_TYPE_B+:2] = state_reg.clk_type;
			end
			rfcs_pkg::IDX_CLK_DIV: begin
				hit  = 1'b1;
				rval = {24'h0, state_reg.clk_div};
			end
			rfcs_pkg::IDX_CLK_OUT: begin
				hit = 1'b1;
				rval[rfcs_pkg::CLK_AMP_B+:2]  = state_reg.clk_amp;
				rval[rfcs_pkg::CLK_DC_B+:2]   = state_reg.clk_dc;
				rval[rfcs_pkg::CLK_CMOS_B+:3] = state_reg.clk_cmos;
			end
			rfcs_pkg::IDX_ADC_CFG_D: begin
				hit = 1'b1;
				rval[rfcs_pkg::ADCD_ANA_B]    = state_reg.analog[NCH-1];
				rval[rfcs_pkg::ADCD_LVL_B+:2]  = state_reg.adc_lvl[NCH-1];
				rval[rfcs_pkg::ADCD_MODE_B+:2] = state_reg.adc_mode[NCH-1];
			end
			default: begin
				hit  = 1'b0;
				rval = '0;
			end
		endcase
		for (int c = 0; c < NWB; c++) begin
			if (idx == rfcs_pkg::IDX_ADC_CFG + 8'(c) * rfcs_pkg::CH_STRIDE) begin
				hit = 1'b1;
				rval[rfcs_pkg::ADC_ANA_B]    = state_reg.analog[c];
				rval[rfcs_pkg::ADC_LVL_B+:2]  = state_reg.adc_lvl[c];
				rval[rfcs_pkg::ADC_MODE_B+:2] = state_reg.adc_mode[c];
			end
			if (idx == rfcs_pkg::IDX_ANT_CUR + 8'(c) * rfcs_pkg::CH_STRIDE) begin
				hit = 1'b1;
				rval[rfcs_pkg::ANT_SET_B+:4] = state_reg.cur_set[c];
				rval[rfcs_pkg::ANT_LIM_B]    = state_reg.lim_min[c];
			end
			if (idx == rfcs_pkg::IDX_ANT_CTL + 8'(c) * rfcs_pkg::CH_STRIDE) begin
				hit = 1'b1;
				rval[rfcs_pkg::CTL_AUTO_B]  = state_reg.auto_en[c];
				rval[rfcs_pkg::CTL_DET_B]   = state_reg.det_en[c];
				rval[rfcs_pkg::CTL_AMPEN_B] = state_reg.amp_en[c];
				rval[rfcs_pkg::CTL_TYPE_B]  = state_reg.amp_type[c];
			end
			if (idx == rfcs_pkg::IDX_ANT_STAT + 8'(c) * rfcs_pkg::CH_STRIDE) begin
				hit = 1'b1;
				rval[rfcs_pkg::ST_AMP_B+:2] = amp_status[c];
				rval[rfcs_pkg::ST_CONN_B]   = ant_conn_fail[c];
				rval[rfcs_pkg::ST_CUR_B]    = ant_cur_fail[c];
			end
		end
		// misaligned byte address is treated as unmapped
		if (paddr[1:0] != 2'h0) begin
			hit = 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// next state
	always_comb begin
		state_next = state_reg;
		// hardware clear first so a software start in the same cycle wins
		if (temp_finish) begin
			state_next.temp_start = 1'b0;
		end
		if (setup) begin
			state_next.rdata = hit ? rval : 32'h0;
			state_next.err   = ~hit;
		end
		if (wr && !state_reg.err) begin
			case (idx)
				rfcs_pkg::IDX_TEMP_CTL: begin
					state_next.temp_mode = pwdata[rfcs_pkg::TMP_MODE_B];
					if (pwdata[rfcs_pkg::TMP_START_B]) begin
						state_next.temp_start = 1'b1;
					end
				end
				rfcs_pkg::IDX_CLK_SRC: begin
					state_next.clk_src  = pwdata[rfcs_pkg::CLK_SRC_B+:3];
					state_next.clk_type = pwdata[rfcs_pkg::CLK_TYPE_B+:2];
				end
				rfcs_pkg::IDX_CLK_DIV: begin
					state_next.clk_div = pwdata[7:0];
				end
				rfcs_pkg::IDX_CLK_OUT: begin
					state_next.clk_amp  = pwdata[rfcs_pkg::CLK_AMP_B+:2];
					state_next.clk_dc   = pwdata[rfcs_pkg::CLK_DC_B+:2];
					state_next.clk_cmos = pwdata[rfcs_pkg::CLK_CMOS_B+:3];
				end
				rfcs_pkg::IDX_ADC_CFG_D: begin
					state_next.analog[NCH-1]   = pwdata[rfcs_pkg::ADCD_ANA_B];
					state_next.adc_lvl[NCH-1]  = pwdata[rfcs_pkg::ADCD_LVL_B+:2];
					state_next.adc_mode[NCH-1] = pwdata[rfcs_pkg::ADCD_MODE_B+:2];
				end
				default: begin
				end
			endcase
			for (int c = 0; c < NWB; c++) begin
				if (idx == rfcs_pkg::IDX_ADC_CFG + 8'(c) * rfcs_pkg::CH_STRIDE) begin
					state_next.analog[c]   = pwdata[rfcs_pkg::ADC_ANA_B];
					state_next.adc_lvl[c]  = pwdata[rfcs_pkg::ADC_LVL_B+:2];
					state_next.adc_mode[c] = pwdata[rfcs_pkg::ADC_MODE_B+:2];
				end
				if (idx == rfcs_pkg::IDX_ANT_CUR + 8'(c) * rfcs_pkg::CH_STRIDE) begin
					state_next.cur_set[c] = pwdata[rfcs_pkg::ANT_SET_B+:4];
					state_next.lim_min[c] = pwdata[rfcs_pkg::ANT_LIM_B];
				end
				if (idx == rfcs_pkg::IDX_ANT_CTL + 8'(c) * rfcs_pkg::CH_STRIDE) begin
					// all four bits land together on every write, so the ordered manual sequence works
					state_next.auto_en[c]  = pwdata[rfcs_pkg::CTL_AUTO_B];
					state_next.det_en[c]   = pwdata[rfcs_pkg::CTL_DET_B];
					state_next.amp_en[c]   = pwdata[rfcs_pkg::CTL_AMPEN_B];
					state_next.amp_type[c] = pwdata[rfcs_pkg::CTL_TYPE_B];
				end
			end
		end
	end

	always_ff @(posedge clk) begin
		if (!reset_n) begin
			state_reg          <= '0;
			state_reg.adc_mode <= {NCH{rfcs_pkg::RST_ADC_MODE}};
			state_reg.adc_lvl  <= {NCH{rfcs_pkg::RST_ADC_LVL}};
			state_reg.cur_set  <= {NWB{rfcs_pkg::RST_CUR_SET}};
			state_reg.auto_en  <= '1;
			state_reg.det_en   <= '1;
			state_reg.amp_en   <= '1;
			state_reg.clk_src  <= rfcs_pkg::SRC_SYNTH_FIRST;
			state_reg.clk_div  <= rfcs_pkg::RST_CLK_DIV;
			state_reg.clk_type <= rfcs_pkg::CLKO_LVDS;
			state_reg.clk_amp  <= rfcs_pkg::RST_CLK_AMP;
			state_reg.clk_dc   <= rfcs_pkg::RST_CLK_DC;
			state_reg.clk_cmos <= rfcs_pkg::RST_CLK_CMOS;
		end else begin
			state_reg <= state_next;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// detector per wideband channel
	for (genvar g = 0; g < NWB; g++) begin : g_ant
		rfcs_antenna u_ant (
			.clk          (clk),
			.reset_n      (reset_n),
			.cur_set      (state_reg.cur_set[g]),
			.lim_min      (state_reg.lim_min[g]),
			.det_en       (state_reg.det_en[g]),
			.auto_en      (state_reg.auto_en[g]),
			.amp_en       (state_reg.amp_en[g]),
			.amp_type     (state_reg.amp_type[g]),
			.meas_cur     (ant_meas_cur[g]),
			.conn_fail    (ant_conn_fail[g]),
			.cur_fail     (ant_cur_fail[g]),
			.limit_preset (ant_limit_preset[g]),
			.limit_active (ant_limit_active[g]),
			.amp_status   (amp_status[g])
		);
		assign first_input_amplifier_on[g]  = amp_status[g][0];
		assign second_input_amplifier_on[g] = amp_status[g][1];
	end

	////////////////////////////////////////////////////////////////////////
	// temperature sequencer
	rfcs_temp #(
		.MEAS_CYC   (TEMP_MEAS_CYCLES),
		.PERIOD_CYC (TEMP_PERIOD_CYCLES)
	) u_temp (
		.clk          (clk),
		.reset_n      (reset_n),
		.start        (state_reg.temp_start),
		.cont_mode    (state_reg.temp_mode),
		.sensor_value (temp_sensor_value),
		.finish       (temp_finish),
		.sense_en     (temp_sense_en),
		.result       (temp_result)
	);

	////////////////////////////////////////////////////////////////////////
	// outputs
	always_comb begin
		for (int c = 0; c < NCH; c++) begin
			// comparators run free in async mode; correlator resamples
			adc_sample_clk_en[c] = (state_reg.adc_mode[c] != rfcs_pkg::ADC_ASYNC);
		end
	end

	assign adc_analog_sel = state_reg.analog;
	assign adc_clk_mode   = state_reg.adc_mode;
	assign adc_high_level = state_reg.adc_lvl;
	assign clk_src_sel    = state_reg.clk_src;
	assign clk_div        = state_reg.clk_div;
	assign clk_out_type   = state_reg.clk_type;
	assign clk_amp        = state_reg.clk_amp;
	assign clk_ecl_dc     = state_reg.clk_dc;
	assign clk_cmos_level = state_reg.clk_cmos;
	assign prdata         = state_reg.rdata;
	assign pslverr        = state_reg.err & psel & penable;
	// zero wait: read data is captured in the setup phase
	assign pready         = 1'b1;

endmodule : rfcs_top

// ==== test/rfcs_assertions.sv ====
// rfcs_assertions: port checks for rfcs_top
// assumes: bound to rfcs_top, one clock, synchronous reset_n
`timescale 1ns/10ps
module rfcs_assertions #(
	parameter int TEMP_MEAS_CYCLES = rfcs_pkg::TEMP_MEAS_CYC
) (
	input wire logic                           clk,
	input wire logic                           reset_n,
	input wire logic                           psel,
	input wire logic                           penable,
	input wire logic                           pwrite,
	input wire logic [9:0]                     paddr,
	input wire logic [31:0]                    pwdata,
	input wire logic [rfcs_pkg::NCH-1:0]       adc_analog_sel,
	input wire logic [rfcs_pkg::NCH-1:0][1:0]  adc_clk_mode,
	input wire logic [rfcs_pkg::NCH-1:0]       adc_sample_clk_en,
	input wire logic [rfcs_pkg::NCH-1:0][1:0]  adc_high_level,
	input wire logic [rfcs_pkg::NWB-1:0]       ant_cur_fail,
	input wire logic [rfcs_pkg::NWB-1:0]       ant_limit_active,
	input wire logic [7:0]                     clk_div,
	input wire logic                           temp_sense_en
);
	localparam logic [9:0] A_ADC = {rfcs_pkg::IDX_ADC_CFG, 2'h0};
	localparam logic [9:0] A_DIV = {rfcs_pkg::IDX_CLK_DIV, 2'h0};
	logic wr;
	int   run_cnt;
	default clocking cb @(posedge clk); endclocking
	default disable iff (!reset_n);
	assign wr = psel && penable && pwrite;
	////////////////////////////////////////////////////////////////////////
	// counted, since a repetition cannot span a whole measurement
	always_ff @(posedge clk) begin
		if (!reset_n)
			run_cnt <= 0;
		else
			run_cnt <= temp_sense_en ? run_cnt + 1 : 0;
	end
	a_meas_bound: assert property (run_cnt <= TEMP_MEAS_CYCLES + 2)
		else $error("measurement runs too long");
	a_analog_write: assert property (wr && paddr == A_ADC |=> adc_analog_sel[0] == $past(pwdata[0]))
		else $error("analog select not written");
	a_mode_write: assert property (wr && paddr == A_ADC |=> adc_clk_mode[0] == $past(pwdata[5:4]))
		else $error("adc mode not written");
	a_level_write: assert property (wr && paddr == A_ADC |=> adc_high_level[0] == $past(pwdata[3:2]))
		else $error("high level not written");
	a_async_noclk: assert property (adc_sample_clk_en[0] == (adc_clk_mode[0] != 2'h0))
		else $error("sample clock wrong for mode");
	a_div_write: assert property (wr && paddr == A_DIV |=> clk_div == $past(pwdata[7:0]))
		else $error("divider not written");
	a_div_stable: assert property ($changed(clk_div) |-> $past(wr) && $past(paddr) == A_DIV)
		else $error("divider changed without write");
	a_limit_cur: assert property (ant_limit_active == ant_cur_fail)
		else $error("limit not tied to over-current");
	c_div_write: cover property (wr && paddr == A_DIV);
	c_meas: cover property ($rose(temp_sense_en));
	c_cur_fail: cover property (ant_cur_fail[0]);
endmodule : rfcs_assertions

// ==== test/rfcs_tb.sv ====
// tb: self-checking bench for rfcs_top over apb
// assumes: rfcs_assertions compiled before; temperature counts shortened
`timescale 1ns/10ps
module tb;
	typedef struct {logic [7:0] i; logic [31:0] d; logic [31:0] e;} rfcs_row_type;
	logic                  clk, reset_n, psel, penable, pwrite, pready, pslverr, err, temp_sense_en;
	logic [9:0]            paddr, temp_sensor_value;
	logic [31:0]           pwdata, prdata, rd, r;
	logic [2:0][5:0]       ant_meas_cur;
	logic [3:0]            adc_analog_sel, adc_sample_clk_en;
	logic [3:0][1:0]       adc_high_level, adc_clk_mode;
	logic [2:0]            ant_conn_fail, ant_cur_fail, ant_limit_active, clk_src_sel, clk_cmos_level;
	logic [2:0]            first_input_amplifier_on, second_input_amplifier_on;
	logic [2:0][3:0]       ant_limit_preset;
	logic [7:0]            clk_div;
	logic [1:0]            clk_out_type, clk_amp, clk_ecl_dc;
	int                    mismatches, n_checks;
	rfcs_row_type          rows [7] = '{'{8'h0B, 32'h5A, 32'h5A}, '{8'h0A, 32'h04, 32'h04},
		'{8'h0C, 32'h7F, 32'h7F}, '{8'h1C, 32'h05, 32'h05}, '{8'h32, 32'h28, 32'h28},
		'{8'h48, 32'h1C, 32'h1C}, '{8'h5D, 32'h4C, 32'h4C}};
	rfcs_top #(.TEMP_MEAS_CYCLES(20), .TEMP_PERIOD_CYCLES(30)) rfcs_top_inst (.*);
	////////////////////////////////////////////////////////////////////////
	task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
		n_checks++;
		if (g !== e) begin
			mismatches++;
			$display("Error %s expected %h seen %h", s, e, g);
		end
	endtask : chk
	task automatic stop_test;
		$display("checks %0d mismatches %0d", n_checks, mismatches);
		if (mismatches == 0 && n_checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : stop_test
	// request held until the edge that sees pready; bounded wait
	task automatic xfer(input logic w, input logic [7:0] i, input logic [31:0] d);
		int n;
		@(posedge clk);
		psel <= 1'h1;
		pwrite <= w;
		paddr <= {i, 2'h0};
		pwdata <= d;
		@(posedge clk);
		penable <= 1'h1;
		for (n = 0; n < 16; n++) begin
			@(posedge clk);
			if (pready === 1'h1)
				break;
		end
		if (n == 16) begin
			mismatches++;
			stop_test();
		end
		rd = prdata;
		err = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
	endtask : xfer
	task automatic ac(input logic [5:0] m, input logic [3:0] e);
		ant_meas_cur[0] <= m;
		repeat (3) @(posedge clk);
		chk("antenna", {28'h0, e}, {28'h0, ant_conn_fail[0], ant_cur_fail[0],
			first_input_amplifier_on[0], second_input_amplifier_on[0]});
	endtask : ac
	task automatic poll;
		int k;
		for (k = 0; k < 100; k++) begin
			xfer(1'h0, 8'h09, 32'h0);
			if (rd[0] === 1'h0)
				break;
		end
		chk("start", 32'h0, {31'h0, rd[0]});
	endtask : poll
	////////////////////////////////////////////////////////////////////////
	initial begin
		clk = 1'h0;
		forever #25 clk = ~clk;
	end
	initial begin
		{reset_n, psel, penable, pwrite, paddr, pwdata} = '0;
		ant_meas_cur = '0;
		temp_sensor_value = 10'h2A5;
		repeat (10) @(posedge clk);
		reset_n <= 1'h1;
		@(posedge clk);
		chk("source", rfcs_pkg::SRC_SYNTH_FIRST, clk_src_sel);
		chk("divider", rfcs_pkg::RST_CLK_DIV, clk_div);
		chk("type", rfcs_pkg::CLKO_LVDS, clk_out_type);
		chk("analog", 32'h0, adc_analog_sel);
		foreach (rows[j]) begin
			xfer(1'h1, rows[j].i, rows[j].d);
			xfer(1'h0, rows[j].i, 32'h0);
			chk("readback", rows[j].e, rd);
		end
		chk("type", rfcs_pkg::CLKO_CMOS, clk_out_type);
		chk("source", 32'h4, clk_src_sel);
		chk("divider", 32'h5A, clk_div);
		chk("cmos level", 32'h7, clk_cmos_level);
		chk("amplitude", 32'h3, clk_amp);
		chk("dc level", 32'h3, clk_ecl_dc);
		chk("analog", 32'h9, adc_analog_sel);
		chk("mode", 32'h2, adc_clk_mode[1]);
		chk("sample en", 32'hE, adc_sample_clk_en);
		chk("level", 32'h2, adc_high_level[1]);
		xfer(1'h1, 8'h0A, 32'h0C);
		#1 chk("type", rfcs_pkg::CLKO_ECL, clk_out_type);
		xfer(1'h1, 8'h01, 32'hFF);
		chk("slave error", 32'h1, err);
		xfer(1'h1, 8'h21, 32'h80);
		ac(6'h02, 4'h9);
		ac(6'h03, 4'h2);
		ac(6'h10, 4'h6);
		xfer(1'h0, 8'h0E, 32'h0);
		chk("status", 32'h42, rd);
		chk("limit", 32'h18, {ant_limit_active[0], ant_limit_preset[0]});
		xfer(1'h1, 8'h21, 32'h81);
		ac(6'h0F, 4'h2);
		chk("limit", 32'h0, {ant_limit_active[0], ant_limit_preset[0]});
		xfer(1'h1, 8'h22, 32'h06);
		xfer(1'h1, 8'h22, 32'h07);
		ac(6'h03, 4'h1);
		xfer(1'h1, 8'h22, 32'h03);
		ac(6'h01, 4'h1);
		xfer(1'h1, 8'h09, 32'h1);
		xfer(1'h0, 8'h09, 32'h0);
		chk("start", 32'h1, {31'h0, rd[0]});
		poll();
		xfer(1'h0, 8'h04, 32'h0);
		r = rd;
		xfer(1'h0, 8'h05, 32'h0);
		chk("result", 32'h2A5, {22'h0, r[1:0], rd[7:0]});
		temp_sensor_value <= 10'h15A;
		repeat (40) @(posedge clk);
		xfer(1'h0, 8'h05, 32'h0);
		chk("held", 32'hA5, {24'h0, rd[7:0]});
		xfer(1'h1, 8'h09, 32'h2);
		xfer(1'h1, 8'h09, 32'h3);
		repeat (75) @(posedge clk);
		xfer(1'h0, 8'h05, 32'h0);
		chk("result", 32'h5A, {24'h0, rd[7:0]});
		xfer(1'h0, 8'h09, 32'h0);
		chk("start", 32'h1, {31'h0, rd[0]});
		xfer(1'h1, 8'h09, 32'h0);
		poll();
		repeat (40) @(posedge clk);
		chk("sensing", 32'h0, temp_sense_en);
		stop_test();
	end
endmodule : tb
bind rfcs_top rfcs_assertions #(.TEMP_MEAS_CYCLES(TEMP_MEAS_CYCLES)) rfcs_assertions_inst (.*);
